// File: hdl/scg_pkg.sv
package scg_pkg;

  // reset configuration word fields that the clock unit uses
  typedef struct packed {
    logic [3:0] sys_mult; // system_pll_multiplier
    logic [3:0] core_mult; // core_pll_multiplier
    logic mem_mode; // memory_clock_mode
    logic lb_mode; // local_bus_clock_mode
  } scg_rcw_s;

  localparam int SCG_UNITS = 5;
  localparam int SCG_BUS_OUTS = 5;
  localparam int SCG_LB_OUTS = 3;

  // unit indices into the unit mode vector
  localparam int SCG_U_ETH1 = 0;
  localparam int SCG_U_SERIAL = 1;
  localparam int SCG_U_CRYPTO = 2;
  localparam int SCG_U_USB = 3;
  localparam int SCG_U_BUSDMA = 4;

  typedef enum logic [1:0] {
    SCG_MODE_OFF   = 2'h0,
    SCG_MODE_FULL  = 2'h1,
    SCG_MODE_HALF  = 2'h2,
    SCG_MODE_THIRD = 2'h3
  } scg_mode_e;

  // local bus divide select codes
  localparam logic [1:0] SCG_LBDIV_2 = 2'h1;
  localparam logic [1:0] SCG_LBDIV_4 = 2'h2;
  localparam logic [1:0] SCG_LBDIV_8 = 2'h3;

  // hard-coded reset option sets (index 0 means take the word from pins)
  localparam logic [1:0] SCG_HARD_NONE = 2'h0;
  localparam scg_rcw_s SCG_HARD_A = '{sys_mult: 4'h4, core_mult: 4'h2, mem_mode: 1'b1,
                                      lb_mode: 1'b0};
  localparam scg_rcw_s SCG_HARD_B = '{sys_mult: 4'h6, core_mult: 4'h2, mem_mode: 1'b1,
                                      lb_mode: 1'b1};
  localparam scg_rcw_s SCG_HARD_C = '{sys_mult: 4'h3, core_mult: 4'h3, mem_mode: 1'b0,
                                      lb_mode: 1'b0};

  localparam logic [3:0] SCG_SYSMULT_X16 = 4'h0;
  localparam logic [3:0] SCG_SYSMULT_RSVD = 4'h1;
  localparam logic [4:0] SCG_FACTOR_16 = 5'h10;

  localparam logic [15:0] SCG_CORE_MIN_MHZ = 16'h00c8;
  localparam logic [15:0] SCG_GRADE_266 = 16'h010a;
  localparam logic [15:0] SCG_GRADE_333 = 16'h014d;
  localparam logic [15:0] SCG_GRADE_400 = 16'h0190;

  // status bundle derived from the latched configuration
  typedef struct packed {
    logic [5:0]  system_ratio;  // system bus clock : sync input
    logic [4:0]  system_factor; // decoded multiplier
    logic sys_mult_reserved;
    logic [1:0]  memory_ratio;  // memory ctrl clock : system bus clock
    logic [1:0]  local_ratio;   // local bus unit clock : system bus clock
    logic        core_in_range;
  } scg_status_s;

endpackage : scg_pkg

// File: hdl/scg_clock_unit.sv
`timescale 1ns/1ps
// How it works
// - host mode uses primary_clock_in, agent mode uses agent_clock_in
// - host primary clock feeds a divide-by-two stage beside the undivided clock
// - sync_clock_out carries undivided or halved clock per input_divide_strap
// - each bus clock output picks undivided or halved via its out_clock_div_sel
// - system bus ratio is (1 + strap) times the system multiplier factor
// - processor clock is system bus clock times core_pll_multiplier
// - multiplier and mode fields latched at reset, or from hard option sets
// - memory ctrl clock is system times (1 + mode), halved to differential pair
// - memory data moves once per memory ctrl clock cycle
// - local bus unit clock is system times (1 + mode), divided to outputs
// - local bus divider ratio comes from local_bus_divide_select
// - local bus clock is one half, quarter or eighth of unit clock
// - units leave reset at a default ratio that software may change or stop
// - four units default to third rate; bus-and-DMA defaults full, off/full only
// - processor clock lies between 200 MHz and the speed grade maximum; the code does not enforce it, only flags it in core_in_range
// - system multiplier: 0000 is times sixteen, 0001 reserved, others binary
module scg_clock_unit
  import scg_pkg::*;
#(
  parameter logic [15:0] GRADE_MHZ = SCG_GRADE_400
) (
  input wire logic i_clk,                                // twice the system bus rate
  input wire logic i_srst,                               // sync reset, active high
  input wire logic i_host_mode,                          // 1 host, 0 agent
  input wire logic i_primary_clock_in,                   // host clock level
  input wire logic i_agent_clock_in,                     // agent clock level
  input wire logic i_input_divide_strap,                 // divide strap level
  input wire logic [SCG_BUS_OUTS-1:0] i_out_clock_div_sel, // 1 selects halved
  input wire scg_rcw_s i_reset_config_word_low,          // word sampled at reset
  input wire logic [1:0] i_hard_option,                  // 0 pins, else hard set
  input wire logic [1:0] i_local_bus_divide_select,      // local divider code
  input wire logic i_unit_mode_we,                       // unit mode write strobe
  input wire logic [2*SCG_UNITS-1:0] i_unit_mode,        // new unit modes
  input wire logic [6:0] i_primary_freq_mhz,             // input clock in MHz
  output logic o_sync_clock_out,                         // sync output
  output logic [SCG_BUS_OUTS-1:0] o_bus_clock_outs,      // bus clock outputs
  output logic o_memory_bus_clock_p,                     // memory clock true
  output logic o_memory_bus_clock_n,                     // memory clock complement
  output logic o_memory_data_tick,                       // one pulse per data beat
  output logic o_local_bus_sync_out,                     // local bus sync clock
  output logic [SCG_LB_OUTS-1:0] o_local_bus_clock_outs, // local bus clocks
  output logic [SCG_UNITS-1:0] o_unit_clk_en,            // unit clock enables
  output logic [2*SCG_UNITS-1:0] o_unit_mode,            // active unit modes
  output scg_rcw_s o_rcw,                                // latched configuration
  output scg_status_s o_status,                          // derived ratios
  output logic [15:0] o_core_mhz                         // processor clock MHz
);

  ////////////////////////////////////////////////////////////////////////////
  // configuration latch

  scg_rcw_s rcw_q;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      case (i_hard_option)
        SCG_HARD_NONE: rcw_q <= i_reset_config_word_low;
        2'h1: rcw_q <= SCG_HARD_A;
        2'h2: rcw_q <= SCG_HARD_B;
        default: rcw_q <= SCG_HARD_C;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // primary clock selection and output muxes

  logic prim_q;
  logic prim_prev_q;
  logic half_q;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      prim_q <= 1'b0;
      prim_prev_q <= 1'b0;
    end else begin
      prim_q <= i_host_mode ? i_primary_clock_in : i_agent_clock_in;
      prim_prev_q <= prim_q;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      half_q <= 1'b0;
    end else if (prim_q && !prim_prev_q) begin
      half_q <= !half_q;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_sync_clock_out <= 1'b0;
    end else begin
      o_sync_clock_out <= i_input_divide_strap ? half_q : prim_prev_q;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_bus_clock_outs <= '0;
    end else begin
      for (int n = 0; n < SCG_BUS_OUTS; n++) begin
        o_bus_clock_outs[n] <= i_out_clock_div_sel[n] ? half_q : prim_prev_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ratios and processor range

  function automatic logic [4:0] sys_mult_factor(input logic [3:0] code);
    if (code == SCG_SYSMULT_X16) begin
      return SCG_FACTOR_16;
    end else begin
      return {1'b0, code};
    end
  endfunction : sys_mult_factor

  logic [4:0] factor;
  logic [11:0] csb_mhz;
  logic [15:0] core_mhz;

  assign factor = sys_mult_factor(rcw_q.sys_mult);
  // host: input clock already equals sync input times (1 + strap)
  assign csb_mhz = 12'(i_primary_freq_mhz) * (i_host_mode ? 12'h001 :
                   12'(i_input_divide_strap) + 12'h001) * 12'(factor);
  assign core_mhz = 16'(csb_mhz) * 16'(rcw_q.core_mult);

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_rcw <= '0;
    end else begin
      o_rcw <= rcw_q;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_core_mhz <= '0;
    end else begin
      o_core_mhz <= core_mhz;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_status <= '0;
    end else begin
      o_status.system_factor <= factor;
      o_status.system_ratio <= 6'(factor) * (6'(i_input_divide_strap) + 6'h01);
      o_status.sys_mult_reserved <= rcw_q.sys_mult == SCG_SYSMULT_RSVD;
      o_status.memory_ratio <= 2'(rcw_q.mem_mode) + 2'h1;
      o_status.local_ratio <= 2'(rcw_q.lb_mode) + 2'h1;
      o_status.core_in_range <= core_mhz >= SCG_CORE_MIN_MHZ && core_mhz <= GRADE_MHZ;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // internal clock ticks: i_clk is twice the system bus rate

  logic phase_q;
  logic csb_tick;
  logic ddr_tick;
  logic lb_tick;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      phase_q <= 1'b0;
    end else begin
      phase_q <= !phase_q;
    end
  end

  assign csb_tick = phase_q;
  assign ddr_tick = rcw_q.mem_mode | phase_q;
  assign lb_tick = rcw_q.lb_mode | phase_q;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_memory_bus_clock_p <= 1'b0;
      o_memory_bus_clock_n <= 1'b1;
    end else if (ddr_tick) begin
      o_memory_bus_clock_p <= !o_memory_bus_clock_p;
      o_memory_bus_clock_n <= o_memory_bus_clock_p;
    end
  end

  // one beat per memory ctrl clock
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_memory_data_tick <= 1'b0;
    end else begin
      o_memory_data_tick <= ddr_tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // local bus divider

  logic [1:0] lb_cnt_q;
  logic [1:0] lb_last;

  always_comb begin
    case (i_local_bus_divide_select)
      SCG_LBDIV_4: lb_last = 2'h1;
      SCG_LBDIV_8: lb_last = 2'h3;
      default: lb_last = 2'h0;
    endcase
  end

  // toggle every 1, 2 or 4 unit ticks
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      lb_cnt_q <= '0;
      o_local_bus_sync_out <= 1'b0;
      o_local_bus_clock_outs <= '0;
    end else if (lb_tick) begin
      if (lb_cnt_q >= lb_last) begin
        lb_cnt_q <= '0;
        o_local_bus_sync_out <= !o_local_bus_sync_out;
        o_local_bus_clock_outs <= {SCG_LB_OUTS{!o_local_bus_sync_out}};
      end else begin
        lb_cnt_q <= lb_cnt_q + 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configurable unit clocks

  for (genvar u = 0; u < SCG_UNITS; u++) begin : g_unit
    localparam logic [1:0] DEF = (u == SCG_U_BUSDMA) ? SCG_MODE_FULL : SCG_MODE_THIRD;
    logic [1:0] req_q;
    logic [1:0] mode_q;
    logic [1:0] cnt_q;
    logic [1:0] last;
    logic [1:0] wr;

    assign wr = i_unit_mode[2*u +: 2];
    assign last = (mode_q == SCG_MODE_THIRD) ? 2'h2 :
                  (mode_q == SCG_MODE_HALF) ? 2'h1 : 2'h0;

    always_ff @(posedge i_clk) begin
      if (i_srst) begin
        req_q <= DEF;
      end else if (i_unit_mode_we) begin
        // bus-and-DMA takes off or full only
        if (u != SCG_U_BUSDMA || wr == SCG_MODE_OFF || wr == SCG_MODE_FULL) begin
          req_q <= wr;
        end
      end
    end

    // new ratio only at a period boundary
    // switching mid-period would leave a runt pulse
    always_ff @(posedge i_clk) begin
      if (i_srst) begin
        mode_q <= DEF;
        cnt_q <= '0;
      end else if (csb_tick) begin
        if (cnt_q >= last) begin
          cnt_q <= '0;
          mode_q <= req_q;
        end else begin
          cnt_q <= cnt_q + 2'h1;
        end
      end
    end

    always_ff @(posedge i_clk) begin
      if (i_srst) begin
        o_unit_clk_en[u] <= 1'b0;
        o_unit_mode[2*u +: 2] <= DEF;
      end else begin
        o_unit_clk_en[u] <= csb_tick && cnt_q == '0 && mode_q != SCG_MODE_OFF;
        o_unit_mode[2*u +: 2] <= mode_q;
      end
    end
  end

endmodule : scg_clock_unit

// File: verif/scg_clock_unit_checker.sv
`timescale 1ns/1ps
module scg_clock_unit_checker
  import scg_pkg::*;
#(
  parameter logic [15:0] GRADE_MHZ = SCG_GRADE_400
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_host_mode,
  input wire logic i_primary_clock_in,
  input wire logic i_agent_clock_in,
  input wire logic i_input_divide_strap,
  input wire logic [SCG_BUS_OUTS-1:0] i_out_clock_div_sel,
  input wire logic o_sync_clock_out,
  input wire logic [SCG_BUS_OUTS-1:0] o_bus_clock_outs,
  input wire logic o_memory_bus_clock_p,
  input wire logic o_memory_bus_clock_n,
  input wire logic o_local_bus_sync_out,
  input wire logic [SCG_LB_OUTS-1:0] o_local_bus_clock_outs,
  input wire logic [SCG_UNITS-1:0] o_unit_clk_en,
  input wire logic [2*SCG_UNITS-1:0] o_unit_mode,
  input wire scg_rcw_s o_rcw,
  input wire scg_status_s o_status,
  input wire logic [15:0] o_core_mhz
);
  // cycles since reset release, saturating
  logic [2:0] up_q;
  logic ok;
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      up_q <= 3'h0;
    end else if (up_q != 3'h7) begin
      up_q <= up_q + 3'h1;
    end
  end
  assign ok = (up_q == 3'h7);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  ////////////////////////////////////////////////////////////////////////////
  sequence third_pulse_s;
    o_unit_clk_en[0] && o_unit_mode[1:0] == SCG_MODE_THIRD;
  endsequence
  mem_pair_a: assert property (o_memory_bus_clock_n == !o_memory_bus_clock_p)
    else $error("memory clock pair not complementary");
  lb_copies_a: assert property (o_local_bus_clock_outs == {3{o_local_bus_sync_out}})
    else $error("local bus clocks differ");
  bdma_mode_a: assert property (o_unit_mode[9:8] <= 2'h1)
    else $error("bus and dma unit mode out of range");
  mult_decode_a: assert property (ok && o_rcw.sys_mult != SCG_SYSMULT_RSVD |->
    o_status.system_factor == (o_rcw.sys_mult == 4'h0 ? 5'h10 : {1'b0, o_rcw.sys_mult}))
    else $error("system factor decode wrong");
  mult_rsvd_a: assert property (ok |->
    o_status.sys_mult_reserved == (o_rcw.sys_mult == SCG_SYSMULT_RSVD))
    else $error("reserved multiplier flag wrong");
  sys_ratio_a: assert property (ok |->
    o_status.system_ratio == (1 + i_input_divide_strap) * o_status.system_factor)
    else $error("system ratio wrong");
  sub_ratio_a: assert property (ok |-> o_status.memory_ratio == 1 + o_rcw.mem_mode
    && o_status.local_ratio == 1 + o_rcw.lb_mode)
    else $error("memory or local ratio wrong");
  core_range_a: assert property (ok |-> o_status.core_in_range ==
    (o_core_mhz >= SCG_CORE_MIN_MHZ && o_core_mhz <= GRADE_MHZ))
    else $error("core range flag wrong");
  sync_pass_a: assert property (ok && !i_input_divide_strap |-> o_sync_clock_out ==
    (i_host_mode ? $past(i_primary_clock_in, 3) : $past(i_agent_clock_in, 3)))
    else $error("sync output not the undivided input");
  bus_pass_a: assert property (ok && i_host_mode |->
    ((o_bus_clock_outs ^ {SCG_BUS_OUTS{$past(i_primary_clock_in, 3)}})
    & ~$past(i_out_clock_div_sel)) == '0)
    else $error("bus clock output not the undivided input");
  bus_half_a: assert property (ok && i_input_divide_strap |->
    ((o_bus_clock_outs ^ {SCG_BUS_OUTS{o_sync_clock_out}}) & $past(i_out_clock_div_sel)) == '0)
    else $error("halved bus clock differs from halved sync output");
  third_gap_a: assert property (third_pulse_s |=>
    (!o_unit_clk_en[0] || o_unit_mode[1:0] != SCG_MODE_THIRD)[*5])
    else $error("third rate enables too close");
endmodule : scg_clock_unit_checker

// File: verif/scg_clock_source.sv
`timescale 1ns/1ps
module scg_clock_source #(
  parameter int HOST_HALF = 4,
  parameter int AGENT_HALF = 3
) (
  input wire logic i_clk, // bench clock
  input wire logic i_host_mode, // 1 host
  output logic o_primary_clock_in, // host clock
  output logic o_agent_clock_in // agent clock
);
  int hc = 0;
  int ac = 0;
  // free running inputs of 25 and 33 MHz
  always_ff @(posedge i_clk) begin
    hc <= (hc == 2 * HOST_HALF - 1) ? 0 : hc + 1;
    ac <= (ac == 2 * AGENT_HALF - 1) ? 0 : ac + 1;
  end
  // host input held low in agent mode
  assign o_primary_clock_in = i_host_mode && (hc < HOST_HALF);
  assign o_agent_clock_in = (ac < AGENT_HALF);
endmodule : scg_clock_source

// File: verif/tb.sv
`timescale 1ns/1ps
module tb;
  import scg_pkg::*;
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_host_mode = 1'b1;
  logic i_primary_clock_in;
  logic i_agent_clock_in;
  logic i_input_divide_strap = 1'b0;
  logic [4:0] i_out_clock_div_sel = 5'h0;
  scg_rcw_s i_reset_config_word_low = '0;
  logic [1:0] i_hard_option = 2'h0;
  logic [1:0] i_local_bus_divide_select = 2'h1;
  logic i_unit_mode_we = 1'b0;
  logic [9:0] i_unit_mode = 10'h1ff;
  logic [6:0] i_primary_freq_mhz = 7'h21;
  logic o_sync_clock_out, o_memory_bus_clock_p, o_memory_bus_clock_n;
  logic o_memory_data_tick, o_local_bus_sync_out;
  logic [4:0] o_bus_clock_outs, o_unit_clk_en;
  logic [2:0] o_local_bus_clock_outs;
  logic [9:0] o_unit_mode;
  scg_rcw_s o_rcw;
  scg_status_s o_status;
  logic [15:0] o_core_mhz;
  int errors = 0;
  int checks = 0;
  scg_clock_source src (.i_clk(i_clk), .i_host_mode(i_host_mode),
    .o_primary_clock_in(i_primary_clock_in), .o_agent_clock_in(i_agent_clock_in));
  scg_clock_unit dut (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_host_mode(i_host_mode),
    .i_primary_clock_in(i_primary_clock_in),
    .i_agent_clock_in(i_agent_clock_in),
    .i_input_divide_strap(i_input_divide_strap),
    .i_out_clock_div_sel(i_out_clock_div_sel),
    .i_reset_config_word_low(i_reset_config_word_low),
    .i_hard_option(i_hard_option),
    .i_local_bus_divide_select(i_local_bus_divide_select),
    .i_unit_mode_we(i_unit_mode_we),
    .i_unit_mode(i_unit_mode),
    .i_primary_freq_mhz(i_primary_freq_mhz),
    .o_sync_clock_out(o_sync_clock_out),
    .o_bus_clock_outs(o_bus_clock_outs),
    .o_memory_bus_clock_p(o_memory_bus_clock_p),
    .o_memory_bus_clock_n(o_memory_bus_clock_n),
    .o_memory_data_tick(o_memory_data_tick),
    .o_local_bus_sync_out(o_local_bus_sync_out),
    .o_local_bus_clock_outs(o_local_bus_clock_outs),
    .o_unit_clk_en(o_unit_clk_en),
    .o_unit_mode(o_unit_mode),
    .o_rcw(o_rcw),
    .o_status(o_status),
    .o_core_mhz(o_core_mhz)
  );
  initial begin
    forever #2.5 i_clk = ~i_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  function automatic logic pick(input int s);
    case (s)
      0: return o_sync_clock_out;
      1: return o_bus_clock_outs[0];
      2: return o_memory_bus_clock_p;
      3: return o_local_bus_sync_out;
      default: return o_unit_clk_en[s - 4];
    endcase
  endfunction : pick
  function automatic int exp_core(input scg_rcw_s e);
    return int'(i_primary_freq_mhz) * (i_host_mode ? 1 : 1 + i_input_divide_strap)
      * (e.sys_mult == 4'h0 ? 16 : e.sys_mult) * e.core_mult;
  endfunction : exp_core
  // cycles between two rising edges, 0 if none
  task automatic period_of(input int s, output int n);
    int first;
    int rises;
    logic prev;
    rises = 0;
    first = 0;
    n = 0;
    prev = pick(s);
    for (int k = 0; k < 400 && rises < 2; k++) begin
      @(posedge i_clk);
      #1;
      if (pick(s) && !prev) begin
        if (rises == 1) n = k - first;
        first = k;
        rises++;
      end
      prev = pick(s);
    end
  endtask : period_of
  task automatic run_test(input int t);
    scg_rcw_s w;
    scg_rcw_s e;
    logic [9:0] m;
    int n;
    int k;
    @(posedge i_clk);
    i_srst <= 1'b1;
    w = scg_rcw_s'($urandom);
    if (w.sys_mult == SCG_SYSMULT_RSVD) w.sys_mult = 4'h2;
    i_reset_config_word_low <= w;
    i_hard_option <= (t < 4) ? 2'(t) : 2'($urandom);
    i_host_mode <= 1'($urandom);
    i_input_divide_strap <= 1'($urandom);
    i_out_clock_div_sel <= 5'($urandom);
    i_local_bus_divide_select <= (t < 4) ? 2'(t) : 2'($urandom);
    // input frequency inside 25 to 66 MHz
    i_primary_freq_mhz <= 7'(25 + $urandom_range(41));
    repeat (3) @(posedge i_clk);
    i_srst <= 1'b0;
    repeat (8) @(posedge i_clk);
    #1;
    case (i_hard_option)
      2'h1: e = SCG_HARD_A;
      2'h2: e = SCG_HARD_B;
      2'h3: e = SCG_HARD_C;
      default: e = w;
    endcase
    check(32'(o_rcw), 32'(e));
    check(32'(o_core_mhz), 32'(16'(exp_core(e))));
    check(32'(o_unit_mode), 32'h1ff);
    period_of(0, n);
    check(n, (i_host_mode ? 8 : 6) * (i_input_divide_strap ? 2 : 1));
    if (i_host_mode) begin
      period_of(1, n);
      check(n, i_out_clock_div_sel[0] ? 16 : 8);
    end
    period_of(2, n);
    check(n, e.mem_mode ? 2 : 4);
    k = 0;
    repeat (8) begin
      @(posedge i_clk);
      #1;
      k += o_memory_data_tick;
    end
    check(k, e.mem_mode ? 8 : 4);
    period_of(3, n);
    k = (i_local_bus_divide_select == 2'h3) ? 4 : (i_local_bus_divide_select == 2'h2) ? 2 : 1;
    check(n, 2 * k * (e.lb_mode ? 1 : 2));
    m = 10'($urandom);
    if (t == 0) m[1:0] = SCG_MODE_OFF;
    if (m[2*SCG_U_CRYPTO +: 2] == SCG_MODE_FULL) m[2*SCG_U_CRYPTO +: 2] = SCG_MODE_HALF;
    if (m[2*SCG_U_USB +: 2] == SCG_MODE_FULL) m[2*SCG_U_USB +: 2] = SCG_MODE_HALF;
    @(posedge i_clk);
    i_unit_mode <= m;
    i_unit_mode_we <= 1'b1;
    @(posedge i_clk);
    i_unit_mode_we <= 1'b0;
    repeat (10) @(posedge i_clk);
    #1;
    check(32'(o_unit_mode), {22'h0, m[9] ? 2'h1 : m[9:8], m[7:0]});
    for (int u = 0; u < SCG_UNITS; u++) begin
      period_of(4 + u, n);
      check(n, 2 * int'((u == SCG_U_BUSDMA && m[9]) ? 2'h1 : m[2*u +: 2]));
    end
    $display("test %0d done", t);
  endtask : run_test
  initial begin
    void'($urandom(32'hea360caf));
    repeat (20) @(posedge i_clk);
    i_srst <= 1'b0;
    for (int t = 0; t < 12; t++) run_test(t);
    give_verdict();
  end
  initial begin
    #200000;
    errors++;
    $display("ERROR %0t watchdog expired", $time);
    give_verdict();
  end
endmodule : tb
bind scg_clock_unit scg_clock_unit_checker #(.GRADE_MHZ(GRADE_MHZ)) chk (
  .i_clk(i_clk),
  .i_srst(i_srst),
  .i_host_mode(i_host_mode),
  .i_primary_clock_in(i_primary_clock_in),
  .i_agent_clock_in(i_agent_clock_in),
  .i_input_divide_strap(i_input_divide_strap),
  .i_out_clock_div_sel(i_out_clock_div_sel),
  .o_sync_clock_out(o_sync_clock_out),
  .o_bus_clock_outs(o_bus_clock_outs),
  .o_memory_bus_clock_p(o_memory_bus_clock_p),
  .o_memory_bus_clock_n(o_memory_bus_clock_n),
  .o_local_bus_sync_out(o_local_bus_sync_out),
  .o_local_bus_clock_outs(o_local_bus_clock_outs),
  .o_unit_clk_en(o_unit_clk_en),
  .o_unit_mode(o_unit_mode),
  .o_rcw(o_rcw),
  .o_status(o_status),
  .o_core_mhz(o_core_mhz)
);
